/* src/swdt_consts.svh */
`ifndef SWDT_CONSTS_SVH
`define SWDT_CONSTS_SVH

// Clock rate and strobe window
`define SWDT_CLK_HZ         20000000
`define SWDT_TIMEOUT_MS     800
// Longest time rounds down: 800 ms at 20 MHz
`define SWDT_TIMEOUT_CYC    ((`SWDT_TIMEOUT_MS * (`SWDT_CLK_HZ / 1000)))
`define SWDT_CNT_W          24
// Command values carried by the call
`define SWDT_CMD_OFF        1'b0
`define SWDT_CMD_ON         1'b1
// Length of the system reset pulse in cycles
`define SWDT_RST_CYC        16

`endif

/* src/swdt_pkg.sv */
package swdt_pkg;

  // Command from the firmware call path
  typedef struct packed {
    logic valid;
    logic value;
  } swdt_cmd_t;

  // Watchdog states
  typedef enum logic [2:0] {
    SWDT_OFF   = 3'b001,
    SWDT_ARMED = 3'b010,
    SWDT_FIRE  = 3'b100
  } swdt_state_t;

endpackage

/* src/swdt_pulse.sv */
`timescale 1ns/1ps
`include "swdt_consts.svh"

module swdt_pulse #(
  parameter int unsigned LEN = `SWDT_RST_CYC
) (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic resetn_in,
  // Trigger and pulse
  input  wire logic start_in,
  output logic      pulse_out
);

  logic [7:0] cnt_q;

  // Stretch a one-cycle trigger into a fixed-length reset pulse
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q     <= 8'h00;
      pulse_out <= 1'b0;
    end else if (start_in) begin
      cnt_q     <= 8'(LEN - 1);
      pulse_out <= 1'b1;
    end else if (cnt_q != 8'h00) begin
      cnt_q     <= cnt_q - 8'h01;
      pulse_out <= 1'b1;
    end else begin
      pulse_out <= 1'b0;
    end
  end

endmodule

/* src/swdt_top.sv */
// Function
// [RQ1] Starts disabled; no reset until enabled
// [RQ2] Software strobes at most every 800 ms
// [RQ3] Enabled and 800 ms without strobe: reset
// [RQ4] Timeout reset drives whole-system hardware reset
// [RQ5] Command 1 enables and counts as strobe
// [RQ6] Command 0 disables; no reset afterwards
// [RQ7] Software disables within 800 ms of strobe
// [RQ8] Each strobe restarts interval from zero
`timescale 1ns/1ps
`include "swdt_consts.svh"

module swdt_top #(
  parameter int unsigned TIMEOUT_CYC = `SWDT_TIMEOUT_CYC,
  parameter int unsigned RST_CYC     = `SWDT_RST_CYC
) (
  // Clock and reset
  input  wire logic               clock_in,
  input  wire logic               resetn_in,
  // Firmware command, same clock domain
  input  wire swdt_pkg::swdt_cmd_t cmd_in,
  // Status and system reset
  output logic                    enabled_out,
  output logic                    sys_reset_out
);

  swdt_pkg::swdt_state_t     state_q;
  logic [`SWDT_CNT_W-1:0]    cnt_q;
  logic                      fire_q;
  logic                      pulse_w;
  logic                      resetn_meta_q;
  logic                      resetn_sync_q;

  // Reset synchroniser: asserts at once, releases after two edges
  // The reset pin is asynchronous, so its release must not race the state flops
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      resetn_meta_q <= 1'b0;
      resetn_sync_q <= 1'b0;
    end else begin
      resetn_meta_q <= 1'b1;
      resetn_sync_q <= resetn_meta_q;
    end
  end

  // State: enable, disable and timeout
  // A strobe in the expiry cycle wins, so a live system is never reset
  always_ff @(posedge clock_in or negedge resetn_sync_q) begin
    if (!resetn_sync_q) begin
      state_q <= swdt_pkg::SWDT_OFF; // RQ1
    end else begin
      case (state_q)
        swdt_pkg::SWDT_OFF: begin
          if (cmd_in.valid && cmd_in.value == `SWDT_CMD_ON) begin
            state_q <= swdt_pkg::SWDT_ARMED; // RQ5
          end
        end
        swdt_pkg::SWDT_ARMED: begin
          if (cmd_in.valid && cmd_in.value == `SWDT_CMD_OFF) begin
            state_q <= swdt_pkg::SWDT_OFF; // RQ6
          end else if (!cmd_in.valid && cnt_q == `SWDT_CNT_W'(TIMEOUT_CYC - 1)) begin
            state_q <= swdt_pkg::SWDT_FIRE; // RQ3
          end
        end
        swdt_pkg::SWDT_FIRE: begin
          state_q <= swdt_pkg::SWDT_OFF; // Reset also clears the watchdog
        end
        default: begin
          state_q <= swdt_pkg::SWDT_OFF;
        end
      endcase
    end
  end

  // Interval counter, cleared by every strobe
  // Held at zero outside the armed state, so enabling starts a full window
  always_ff @(posedge clock_in or negedge resetn_sync_q) begin
    if (!resetn_sync_q) begin
      cnt_q <= '0;
    end else if (state_q != swdt_pkg::SWDT_ARMED || (cmd_in.valid && cmd_in.value == `SWDT_CMD_ON)) begin
      cnt_q <= '0; // RQ8
    end else begin
      cnt_q <= cnt_q + `SWDT_CNT_W'(1);
    end
  end

  // One-cycle timeout trigger
  always_ff @(posedge clock_in or negedge resetn_sync_q) begin
    if (!resetn_sync_q) begin
      fire_q <= 1'b0;
    end else begin
      fire_q <= (state_q == swdt_pkg::SWDT_FIRE); // RQ3
    end
  end

  // System reset stretcher
  swdt_pulse #(
    .LEN (RST_CYC)
  ) u_pulse (
    .clock_in  (clock_in),
    .resetn_in (resetn_sync_q),
    .start_in  (fire_q),
    .pulse_out (pulse_w)
  );

  // Registered outputs
  // Both outputs come from flops, so the system reset line never glitches
  always_ff @(posedge clock_in or negedge resetn_sync_q) begin
    if (!resetn_sync_q) begin
      enabled_out   <= 1'b0;
      sys_reset_out <= 1'b0;
    end else begin
      enabled_out   <= (state_q == swdt_pkg::SWDT_ARMED);
      sys_reset_out <= pulse_w; // RQ4
    end
  end

endmodule

/* testbench/swdt_monitor.sv */
`timescale 1ns/1ps
module swdt_monitor #(
  parameter int unsigned TIMEOUT_CYC = 50,
  parameter int unsigned RST_CYC     = 16
) (
  input wire logic                clock_in,
  input wire logic                resetn_in,
  input wire swdt_pkg::swdt_cmd_t cmd_in,
  input wire logic                enabled_out,
  input wire logic                sys_reset_out
);
  logic [31:0] cnt_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  // Edges since the last enable or strobe
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) cnt_q <= 32'h0;
    else if (cmd_in.valid && cmd_in.value) cnt_q <= 32'h1;
    else if (cnt_q < 32'hffff) cnt_q <= cnt_q + 32'h1;
  end
  // Commands outside a reset pulse
  sequence s_on; cmd_in.valid && cmd_in.value && !sys_reset_out; endsequence
  sequence s_off; cmd_in.valid && !cmd_in.value && !sys_reset_out; endsequence
  a_on_enables: assert property (s_on |-> ##3 enabled_out) else $error("enable missed");
  a_off_quiet: assert property (s_off |-> ##3 !enabled_out ##1 (!sys_reset_out)[*8]) else $error("off failed");
  a_reset_cause: assert property ($rose(sys_reset_out) |-> $past(enabled_out, 4) && !enabled_out)
    else $error("reset while off");
  a_timeout_exact: assert property ($rose(sys_reset_out) |-> cnt_q == TIMEOUT_CYC + 4)
    else $error("timeout early");
  a_timeout_fires: assert property (cnt_q == TIMEOUT_CYC + 4 && $past(enabled_out, 4) |-> $rose(sys_reset_out))
    else $error("timeout missed");
  a_pulse_len: assert property ($fell(sys_reset_out) |-> cnt_q == TIMEOUT_CYC + 4 + RST_CYC)
    else $error("pulse length");
endmodule
bind swdt_top swdt_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC), .RST_CYC(RST_CYC)) u_mon (.clock_in(clock_in),
  .resetn_in(resetn_in), .cmd_in(cmd_in), .enabled_out(enabled_out), .sys_reset_out(sys_reset_out));

/* testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; $display("mismatch %0t value", $time); end end
module tb;
  localparam int T = 20;
  localparam int R = 4;
  logic                clock_in = 1'b0;
  logic                resetn_in = 1'b0;
  swdt_pkg::swdt_cmd_t cmd_in = '0;
  logic                enabled_out;
  logic                sys_reset_out;
  logic                hit;
  int                  failures = 0;
  int                  checks = 0;
  int                  n;
  swdt_top #(.TIMEOUT_CYC(T), .RST_CYC(R)) uut (.clock_in(clock_in), .resetn_in(resetn_in),
    .cmd_in(cmd_in), .enabled_out(enabled_out), .sys_reset_out(sys_reset_out));
  always #25 clock_in = ~clock_in;
  task results;
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One firmware call, taken at the second edge
  task send(input logic v);
    @(posedge clock_in) cmd_in <= '{valid: 1'b1, value: v};
    @(posedge clock_in) cmd_in <= '0;
  endtask
  task watch(input int k);
    hit = 1'b0;
    repeat (k) begin @(posedge clock_in); #1; hit |= sys_reset_out; end
  endtask
  task wait_lvl(input logic lvl);
    n = 0;
    while (sys_reset_out !== lvl) begin
      @(posedge clock_in); #1; n++;
      if (n > 200) begin failures++; $display("mismatch %0t timeout", $time); results(); end
    end
  endtask
  task t_idle;
    send(1'b0);
    watch(3 * T);
    `CHK(hit, 1'b0)
    `CHK(enabled_out, 1'b0)
  endtask
  task t_strobe_timeout;
    send(1'b1);
    repeat (4) begin watch(T - 5); send(1'b1); end
    `CHK(hit, 1'b0)
    `CHK(enabled_out, 1'b1)
    wait_lvl(1'b1);
    `CHK(n, T + 3)
    wait_lvl(1'b0);
    `CHK(n, R)
    `CHK(enabled_out, 1'b0)
  endtask
  task t_off;
    send(1'b1);
    watch(10);
    `CHK(enabled_out, 1'b1)
    send(1'b0);
    watch(3 * T);
    `CHK(hit, 1'b0)
    `CHK(enabled_out, 1'b0)
  endtask
  initial begin
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    t_idle();
    t_strobe_timeout();
    t_off();
    results();
  end
endmodule
